/* File: uhft_bit_strobe.sv */
// bit-time strobe generator: fractional divider from the system clock
`timescale 1ns/10ps
module uhft_bit_strobe
   import uhft_pkg::*;
#(
   parameter int NUM = BIT_RATE_MHZ,
   parameter int DEN = CLOCK_MHZ
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // strobe
   input wire logic restart,
   output logic bit_strobe
);
   typedef struct packed {
      logic [8:0] acc;
      logic strobe;
   } uhft_bs_s;
   uhft_bs_s st;
   uhft_bs_s next_st;
   localparam logic [8:0] NUM_W = 9'(NUM);
   localparam logic [8:0] DEN_W = 9'(DEN);
   always_comb begin
      next_st = st;
      next_st.strobe = 1'b0;
      if (restart) begin
         next_st.acc = 9'h000;
      end else if (st.acc + NUM_W >= DEN_W) begin
         next_st.acc = 9'(st.acc + NUM_W - DEN_W);
         next_st.strobe = 1'b1;
      end else begin
         next_st.acc = 9'(st.acc + NUM_W);
      end
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign bit_strobe = st.strobe;
endmodule : uhft_bit_strobe

/* File: uhft_down_counter.sv */
// frame-remaining down counter with reload and toggle copy
`timescale 1ns/10ps
module uhft_down_counter
   import uhft_pkg::*;
#(
   parameter int WIDTH = INTERVAL_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // control
   input wire logic bit_strobe,
   input wire logic force_load,
   input wire logic [WIDTH-1:0] load_value,
   input wire logic load_toggle,
   // state
   output logic [WIDTH-1:0] count,
   output logic toggle,
   output logic reload
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic toggle;
      logic reload;
   } uhft_dc_s;
   uhft_dc_s st;
   uhft_dc_s next_st;
   always_comb begin
      next_st = st;
      next_st.reload = 1'b0;
      if (force_load) begin
         next_st.count = load_value;
         next_st.reload = 1'b1;
      end else if (bit_strobe) begin
         if (st.count == '0) begin
            next_st.count = load_value;
            next_st.toggle = load_toggle;
            next_st.reload = 1'b1;
         end else begin
            next_st.count = st.count - 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign count = st.count;
   assign toggle = st.toggle;
   assign reload = st.reload;
endmodule : uhft_down_counter

/* File: uhft_frame_timer.sv */
// usb host frame timer: interval register, remaining counter, frame number
//
// Function
// - the block holds a 14-bit frame interval in bits 13 to 0.
// - the frame interval is 11,999 bit times after reset.
// - a controller soft reset returns the frame interval to its nominal value.
// - at each frame start the 15-bit largest packet field loads the packet counter.
// - the packet counter gives the largest data in bits one transaction may move now.
// - the 14-bit frame-remaining counter decrements once per bit time while operational.
// - at zero the remaining counter reloads from the interval at the next bit time.
// - at zero the interval toggle is copied into the remaining toggle bit 31.
// - entering operational state reloads the remaining counter from the interval.
// - each reload increments a 16-bit frame number that wraps after its top value.
`timescale 1ns/10ps
module uhft_frame_timer
   import uhft_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // transaction side
   input wire logic packet_used,
   input wire logic [14:0] packet_bits,
   output logic [14:0] packet_budget,
   // frame outputs
   output logic sof_pulse,
   output logic [15:0] frame_number,
   output logic operational,
   output logic soft_reset_busy
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum {
      UHFT_HALT,
      UHFT_RUN
   } uhft_bus_e;
   typedef struct packed {
      logic [13:0] interval;
      logic [14:0] packet_reload;
      logic interval_toggle;
      logic [14:0] packet_count;
      logic [15:0] number;
      uhft_bus_e bus;
      logic [2:0] soft_count;
      logic sof;
      logic [31:0] rdata;
   } uhft_s;
   uhft_s st;
   uhft_s next_st;

   logic bit_strobe;
   logic [13:0] remaining;
   logic remaining_toggle;
   logic reload;
   logic enter_operational;
   logic soft_active;
   logic running;
   logic wr_interval;
   logic wr_control;
   logic ask_soft_reset;
   logic ask_run;
   logic ask_halt;
   logic frame_edge;
   logic budget_spend;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic [14:0] sat_sub(input logic [14:0] a, input logic [14:0] b);
      sat_sub = (a > b) ? 15'(a - b) : 15'h0000;
   endfunction : sat_sub

   function automatic logic [15:0] next_number(input logic [15:0] number);
      next_number = 16'(number + 16'h0001);
   endfunction : next_number

   // ----------------------------------------
   // register fields and words
   // ----------------------------------------
   function automatic logic [13:0] take_interval(input logic [31:0] word);
      take_interval = word[INTERVAL_W-1:0];
   endfunction : take_interval

   function automatic logic [14:0] take_packet(input logic [31:0] word);
      take_packet = word[PACKET_LSB +: PACKET_W];
   endfunction : take_packet

   function automatic logic take_toggle(input logic [31:0] word);
      take_toggle = word[TOGGLE_POS];
   endfunction : take_toggle

   function automatic logic [31:0] interval_word(input logic toggle, input logic [14:0] packet,
         input logic [13:0] interval);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[TOGGLE_POS] = toggle;
      word[PACKET_LSB +: PACKET_W] = packet;
      word[INTERVAL_W-1:0] = interval;
      return word;
   endfunction : interval_word

   function automatic logic [31:0] remaining_word(input logic toggle, input logic [13:0] count);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[TOGGLE_POS] = toggle;
      word[INTERVAL_W-1:0] = count;
      return word;
   endfunction : remaining_word

   function automatic logic [31:0] number_word(input logic [15:0] number);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[NUMBER_W-1:0] = number;
      return word;
   endfunction : number_word

   function automatic logic [31:0] control_word(input logic run, input logic busy);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[CTL_OPERATIONAL_POS] = run;
      word[CTL_SOFT_RESET_POS] = busy;
      return word;
   endfunction : control_word

   // ----------------------------------------
   // control decode
   // ----------------------------------------
   assign soft_active = (st.soft_count != 3'h0);
   assign running = (st.bus == UHFT_RUN);
   assign wr_interval = reg_write && hit(reg_addr, OFS_FRAME_INTERVAL) && !soft_active;
   assign wr_control = reg_write && hit(reg_addr, OFS_CONTROL) && !soft_active;
   assign ask_soft_reset = wr_control && reg_wdata[CTL_SOFT_RESET_POS];
   assign ask_run = wr_control && reg_wdata[CTL_OPERATIONAL_POS];
   assign ask_halt = wr_control && !reg_wdata[CTL_OPERATIONAL_POS];
   assign enter_operational = ask_run && (st.bus == UHFT_HALT);

   // ----------------------------------------
   // frame events
   // ----------------------------------------
   assign frame_edge = reload && !soft_active;
   assign budget_spend = packet_used && !frame_edge && !soft_active;

   // ----------------------------------------
   // submodules
   // ----------------------------------------
   uhft_bit_strobe u_strobe (
      .sys_clk(sys_clk),
      .reset(reset),
      .restart(enter_operational),
      .bit_strobe(bit_strobe)
   );

   uhft_down_counter #(
      .WIDTH(INTERVAL_W)
   ) u_remaining (
      .sys_clk(sys_clk),
      .reset(reset || soft_active),
      .bit_strobe(bit_strobe && running),
      .force_load(enter_operational),
      .load_value(st.interval),
      .load_toggle(st.interval_toggle),
      .count(remaining),
      .toggle(remaining_toggle),
      .reload(reload)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.sof = 1'b0;
      next_st.rdata = 32'h0000_0000;
      if (soft_active) begin
         next_st.soft_count = 3'(st.soft_count - 3'h1);
         next_st.interval = INTERVAL_NOMINAL;
         next_st.interval_toggle = 1'b0;
         next_st.packet_reload = PACKET_RESET;
         next_st.packet_count = 15'h0000;
         next_st.number = 16'h0000;
         next_st.bus = UHFT_HALT;
      end else begin
         if (wr_interval) begin
            next_st.interval = take_interval(reg_wdata);
            next_st.packet_reload = take_packet(reg_wdata);
            next_st.interval_toggle = take_toggle(reg_wdata);
         end
         if (ask_soft_reset) begin
            next_st.soft_count = 3'(SOFT_RESET_CYCLES);
         end
         // bus state: halted or running
         case (st.bus)
            UHFT_HALT: begin
               if (ask_run) begin
                  next_st.bus = UHFT_RUN;
               end
            end
            UHFT_RUN: begin
               if (ask_halt) begin
                  next_st.bus = UHFT_HALT;
               end
            end
            default: begin
               next_st.bus = UHFT_HALT;
            end
         endcase
         if (frame_edge) begin
            next_st.number = next_number(st.number);
            next_st.packet_count = st.packet_reload;
            next_st.sof = running;
         end else if (budget_spend) begin
            next_st.packet_count = sat_sub(st.packet_count, packet_bits);
         end
      end
      if (reg_read) begin
         case (reg_addr)
            OFS_FRAME_INTERVAL: begin
               next_st.rdata = interval_word(st.interval_toggle, st.packet_reload, st.interval);
            end
            OFS_FRAME_REMAINING: begin
               next_st.rdata = remaining_word(remaining_toggle, remaining);
            end
            OFS_FRAME_NUMBER: begin
               next_st.rdata = number_word(st.number);
            end
            OFS_CONTROL: begin
               next_st.rdata = control_word(running, soft_active);
            end
            default: begin
               next_st.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st <= '0;
         st.interval <= INTERVAL_NOMINAL;
         st.packet_reload <= PACKET_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reg_rdata = st.rdata;
   assign packet_budget = st.packet_count;
   assign sof_pulse = st.sof;
   assign frame_number = st.number;
   assign operational = running;
   assign soft_reset_busy = soft_active;
endmodule : uhft_frame_timer

/* File: uhft_frame_timer_bench.sv */
// self-checking bench of the frame timer
`timescale 1ns/10ps
module uhft_frame_timer_bench
   import uhft_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata, d, w;
   logic packet_used, sof_pulse, operational, soft_reset_busy;
   logic [14:0] packet_bits, packet_budget;
   logic [15:0] frame_number;
   logic [3:0] lag = 4'h1;
   logic [14:0] bits_in = 15'h0000;
   logic up = 1'b0;
   int err_count = 0, n_tests = 0, seed = 32'h86571f87;
   int exp_fn = 0, eb = 0, bp = 0, rl = 0, n = 0, c1 = 0;
   uhft_frame_timer u_dut (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .packet_used, .packet_bits, .packet_budget, .sof_pulse,
      .frame_number, .operational, .soft_reset_busy);
   uhft_xact_model u_xact (.sys_clk, .reset, .sof_pulse, .lag, .bits_in, .packet_used,
      .packet_bits);
   task chk(string nm, logic [31:0] e, logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task end_sim;
      if (err_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   task wr(logic [7:0] a, logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : wr
   task rd(logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask : rd
   task wsof;
      n = 0;
      @(negedge sys_clk);
      while (sof_pulse !== 1'b1) begin
         @(negedge sys_clk);
         n++;
         if (n > 5000) begin
            err_count++;
            end_sim;
         end
      end
   endtask : wsof
   // frame count and budget model
   always @(negedge sys_clk) begin
      if (!reset && sof_pulse === 1'b1) begin
         eb = rl;
         exp_fn = (exp_fn + 1) % 65536;
         chk("frame_number", exp_fn, frame_number);
      end else if (up) eb = (eb > bp) ? eb - bp : 0;
      if (!reset && (sof_pulse === 1'b1 || up)) chk("budget", eb, packet_budget);
      up = packet_used === 1'b1;
      bp = packet_bits;
   end
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      rd(OFS_FRAME_INTERVAL);
      chk("interval", {18'h0, INTERVAL_NOMINAL}, d);
      rd(8'h50);
      chk("unmapped", 0, d);
      rl = $random(seed) & 32'h7fff;
      bits_in <= 15'($random(seed));
      w = {1'b1, rl[14:0], 2'b00, 14'd30};
      wr(OFS_FRAME_INTERVAL, w);
      rd(OFS_FRAME_INTERVAL);
      chk("interval", w, d);
      wr(OFS_FRAME_REMAINING, 32'hffff_ffff);
      rd(OFS_FRAME_REMAINING);
      chk("remaining", 0, d);
      wr(OFS_CONTROL, 32'h0000_0002);
      wsof;
      wsof;
      rd(OFS_FRAME_REMAINING);
      c1 = d[13:0];
      chk("toggle", 1, d[31]);
      repeat (50) @(posedge sys_clk);
      rd(OFS_FRAME_REMAINING);
      chk("decrement", 1, {31'h0, (c1 - d[13:0]) inside {[2:3]}});
      wsof;
      wsof;
      chk("frame length", 1, {31'h0, n inside {[643:646]}});
      lag <= 4'h9;
      w = {1'b0, rl[14:0], 2'b00, 14'd20};
      wr(OFS_FRAME_INTERVAL, w);
      wsof;
      wsof;
      chk("frame length", 1, {31'h0, n inside {[435:438]}});
      rd(OFS_FRAME_REMAINING);
      chk("toggle", 0, d[31]);
      wr(OFS_CONTROL, 32'h0000_0003);
      rd(OFS_CONTROL);
      chk("control", 1, d);
      chk("busy_pin", 1, soft_reset_busy);
      wr(OFS_FRAME_INTERVAL, 32'h0000_0005);
      repeat (6) @(posedge sys_clk);
      rd(OFS_FRAME_INTERVAL);
      chk("interval", INTERVAL_NOMINAL, d[13:0]);
      rd(OFS_FRAME_NUMBER);
      chk("frame_number", 0, d);
      exp_fn = 0;
      chk("operational", 0, operational);
      wr(OFS_FRAME_INTERVAL, w);
      wr(OFS_CONTROL, 32'h0000_0002);
      wsof;
      rd(OFS_FRAME_REMAINING);
      chk("reload", 1, {31'h0, d[13:0] inside {[19:20]}});
      end_sim;
   end
endmodule : uhft_frame_timer_bench

/* File: uhft_frame_timer_monitor.sv */
// port assertions of the frame timer
`timescale 1ns/10ps
module uhft_monitor
   import uhft_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // transaction side
   input wire logic packet_used,
   input wire logic [14:0] packet_bits,
   input wire logic [14:0] packet_budget,
   // frame outputs
   input wire logic sof_pulse,
   input wire logic [15:0] frame_number,
   input wire logic operational,
   input wire logic soft_reset_busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_busy;
      soft_reset_busy [*4] ##1 !soft_reset_busy;
   endsequence
   property p_rdata_idle;
      !$past(reg_read) |-> reg_rdata == 32'h0000_0000;
   endproperty
   property p_busy;
      $rose(soft_reset_busy) |-> s_busy;
   endproperty
   property p_op_off;
      $rose(soft_reset_busy) |-> ##[0:4] !operational;
   endproperty
   property p_sof_one;
      sof_pulse |=> !sof_pulse;
   endproperty
   property p_sof_op;
      sof_pulse |-> operational;
   endproperty
   property p_fn_inc;
      sof_pulse |-> frame_number == $past(frame_number) + 16'h0001;
   endproperty
   property p_fn_hold;
      !sof_pulse && !soft_reset_busy && !$past(soft_reset_busy) |-> $stable(frame_number);
   endproperty
   property p_budget_use;
      $past(packet_used) && !sof_pulse && !soft_reset_busy |-> packet_budget ==
         (($past(packet_budget) > $past(packet_bits)) ?
         $past(packet_budget) - $past(packet_bits) : 15'h0000);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
   a_busy: assert property (p_busy) else $error("soft reset length");
   a_op_off: assert property (p_op_off) else $error("still operational");
   a_sof_one: assert property (p_sof_one) else $error("sof too long");
   a_sof_op: assert property (p_sof_op) else $error("sof when idle");
   a_fn_inc: assert property (p_fn_inc) else $error("frame number step");
   a_fn_hold: assert property (p_fn_hold) else $error("frame number moved");
   a_budget_use: assert property (p_budget_use) else $error("budget use");
endmodule : uhft_monitor
bind uhft_frame_timer uhft_monitor u_mon (.sys_clk, .reset, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .packet_used, .packet_bits, .packet_budget,
   .sof_pulse, .frame_number, .operational, .soft_reset_busy);

/* File: uhft_pkg.sv */
// constants and register layout of the usb host frame timer
package uhft_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_FRAME_INTERVAL = 8'h34;
   localparam logic [7:0] OFS_FRAME_REMAINING = 8'h38;
   localparam logic [7:0] OFS_FRAME_NUMBER = 8'h3C;
   localparam logic [7:0] OFS_CONTROL = 8'h40;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int INTERVAL_W = 14;
   localparam int PACKET_W = 15;
   localparam int NUMBER_W = 16;
   localparam int TOGGLE_POS = 31;
   localparam int PACKET_LSB = 16;
   localparam int CTL_SOFT_RESET_POS = 0;
   localparam int CTL_OPERATIONAL_POS = 1;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [13:0] INTERVAL_NOMINAL = 14'd11999;
   localparam logic [14:0] PACKET_RESET = 15'h0000;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLOCK_MHZ = 250;
   localparam int BIT_RATE_MHZ = 12;
   localparam int SOFT_RESET_CYCLES = 4;
   localparam int SOF_PULSE_CYCLES = 1;
endpackage : uhft_pkg

/* File: uhft_xact_model.sv */
// transaction partner spending the packet budget
`timescale 1ns/10ps
module uhft_xact_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // frame side
   input wire logic sof_pulse,
   input wire logic [3:0] lag,
   input wire logic [14:0] bits_in,
   // transaction side
   output logic packet_used,
   output logic [14:0] packet_bits
);
   int cnt = -1;
   initial begin
      packet_used = 1'b0;
      packet_bits = 15'h0000;
   end
   // one transaction lag+1 cycles after the edge that samples each frame start pulse
   always @(posedge sys_clk) begin
      packet_used <= 1'b0;
      packet_bits <= ~packet_bits;
      if (reset) cnt <= -1;
      else if (sof_pulse) cnt <= lag;
      else if (cnt > 0) cnt <= cnt - 1;
      else if (cnt == 0) begin
         packet_used <= 1'b1;
         packet_bits <= bits_in;
         cnt <= -1;
      end
   end
endmodule : uhft_xact_model
